// >>> ssa_pkg.sv
// ssa_pkg: shared constants for the skip-and-subtract execution block
// assumes: one 10 MHz core clock, register port with 9-bit byte index
package ssa_pkg;

    // operation codes presented on op_code
    localparam logic [2:0] OP_INC_SKIP_ZERO  = 3'h0; // increment_skip_zero
    localparam logic [2:0] OP_INC_TO_WORKING = 3'h1; // increment_to_working_skip
    localparam logic [2:0] OP_BIT_SET_SKIP   = 3'h2; // bit_set_skip
    localparam logic [2:0] OP_DIFF_TO_WORK   = 3'h3; // difference_to_working, memory operand
    localparam logic [2:0] OP_DIFF_TO_MEM    = 3'h4; // difference_to_memory
    localparam logic [2:0] OP_DIFF_IMM       = 3'h5; // difference_to_working, immediate

    // register port map: data memory at 0x000..0x0ff, then two registers
    localparam int         MEM_DEPTH      = 256;
    localparam logic [8:0] ADDR_MEM_LAST  = 9'h0ff;
    localparam logic [8:0] ADDR_WORKING   = 9'h100;
    localparam logic [8:0] ADDR_STATUS    = 9'h101;

    // status register field positions
    localparam int STATUS_BORROW_INV_BIT = 0;
    localparam int STATUS_HALF_CARRY_BIT = 1;
    localparam int STATUS_NULL_BIT       = 2;
    localparam int STATUS_SIGNED_BIT     = 3;
    localparam int STATUS_BUSY_BIT       = 7;

    // reset values
    localparam logic [7:0] WORKING_RESET = 8'h00;
    localparam logic [3:0] FLAGS_RESET   = 4'h0;

    // fsm states, one-hot
    typedef enum logic [2:0] {
        SSA_IDLE  = 3'b001,
        SSA_EXEC  = 3'b010,
        SSA_DUMMY = 3'b100
    } ssa_state_e;

endpackage : ssa_pkg

// >>> ssa_alu.sv
// ssa_alu: executes increment/skip, bit-skip and subtract operations on an
// internal data memory and working register, inserting a dummy cycle on skip
// assumes: one clock, op_valid only honoured while busy is low
//
// How it works
// - increment_skip_zero: byte plus one written back; skip if new value zero.
// - increment_to_working_skip: byte plus one into working register; memory kept; skip if zero.
// - a taken skip adds one dummy cycle, so the instruction takes two cycles.
// - bit_set_skip: skip when the selected bit of the byte is one.
// - difference_to_working: working minus byte into working; four flags updated.
// - borrow_inverse flag is 0 for negative difference, 1 for zero or positive.
// - difference_to_memory: working minus byte written to memory; four flags updated.
// - immediate difference: working minus instruction constant into working register.
`timescale 1ns/1ns
module ssa_alu (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // instruction issue
    input  wire logic       op_valid,
    input  wire logic [2:0] op_code,
    input  wire logic [7:0] op_addr,
    input  wire logic [2:0] op_bit,
    input  wire logic [7:0] op_imm,
    output logic            busy,
    output logic            done,
    output logic            skip_taken,
    output logic            dummy_cycle,
    // register port
    input  wire logic [8:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata,
    // flags and working register as plain outputs
    output logic [7:0]      working_register,
    output logic            signed_range_flag,
    output logic            null_result_flag,
    output logic            half_carry_flag,
    output logic            borrow_inverse_flag
);

    logic [7:0]        mem_r [0:ssa_pkg::MEM_DEPTH-1];
    ssa_pkg::ssa_state_e state_r;
    ssa_pkg::ssa_state_e state_nxt;
    logic [2:0]        code_r;
    logic [7:0]        addr_r;
    logic [2:0]        bit_r;
    logic [7:0]        imm_r;
    logic [7:0]        work_r;
    logic              ov_r;
    logic              z_r;
    logic              ac_r;
    logic              c_r;
    logic              busy_r;
    logic              done_r;
    logic              skip_r;
    logic              dummy_r;
    logic [7:0]        rdata_r;

    // operand and result datapath
    logic [7:0]        operand;
    logic [7:0]        sub_rhs;
    logic [7:0]        inc_val;
    logic [8:0]        diff_w;
    logic [7:0]        diff;
    logic              is_sub;
    logic              skip_cond;

    assign operand = mem_r[addr_r];
    assign inc_val = operand + 8'h01; // wraps modulo 256
    assign sub_rhs = (code_r == ssa_pkg::OP_DIFF_IMM) ? imm_r : operand;
    assign diff_w  = {1'b0, work_r} - {1'b0, sub_rhs};
    assign diff    = diff_w[7:0];
    assign is_sub  = (code_r == ssa_pkg::OP_DIFF_TO_WORK) ||
                     (code_r == ssa_pkg::OP_DIFF_TO_MEM)  ||
                     (code_r == ssa_pkg::OP_DIFF_IMM);

    // skip decision for the latched operation
    always_comb
    begin
        case (code_r)
            ssa_pkg::OP_INC_SKIP_ZERO:  skip_cond = (inc_val == 8'h00);
            ssa_pkg::OP_INC_TO_WORKING: skip_cond = (inc_val == 8'h00);
            ssa_pkg::OP_BIT_SET_SKIP:   skip_cond = operand[bit_r];
            default:                    skip_cond = 1'b0;
        endcase
    end

    // next state: exec lasts one cycle, a skip adds the dummy cycle
    always_comb
    begin
        case (state_r)
            ssa_pkg::SSA_IDLE:  state_nxt = op_valid ? ssa_pkg::SSA_EXEC : ssa_pkg::SSA_IDLE;
            ssa_pkg::SSA_EXEC:  state_nxt = skip_cond ? ssa_pkg::SSA_DUMMY
                                                      : ssa_pkg::SSA_IDLE;
            ssa_pkg::SSA_DUMMY: state_nxt = ssa_pkg::SSA_IDLE;
            default:            state_nxt = ssa_pkg::SSA_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            state_r <= ssa_pkg::SSA_IDLE;
        else
            state_r <= state_nxt;
    end

    // latch the instruction when it is taken
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            code_r <= 3'h0;
            addr_r <= 8'h00;
            bit_r  <= 3'h0;
            imm_r  <= 8'h00;
        end
        else if (state_r == ssa_pkg::SSA_IDLE && op_valid)
        begin
            code_r <= op_code;
            addr_r <= op_addr;
            bit_r  <= op_bit;
            imm_r  <= op_imm;
        end
    end

    // handshake outputs
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy_r  <= 1'b0;
            done_r  <= 1'b0;
            skip_r  <= 1'b0;
            dummy_r <= 1'b0;
        end
        else
        begin
            busy_r  <= (state_nxt != ssa_pkg::SSA_IDLE);
            done_r  <= (state_r != ssa_pkg::SSA_IDLE) && (state_nxt == ssa_pkg::SSA_IDLE);
            skip_r  <= (state_r == ssa_pkg::SSA_EXEC) && skip_cond;
            dummy_r <= (state_nxt == ssa_pkg::SSA_DUMMY);
        end
    end

    // working register: exec results win; software writes only while idle
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            work_r <= ssa_pkg::WORKING_RESET;
        else if (state_r == ssa_pkg::SSA_EXEC)
        begin
            if (code_r == ssa_pkg::OP_INC_TO_WORKING)
                work_r <= inc_val;
            else if (code_r == ssa_pkg::OP_DIFF_TO_WORK || code_r == ssa_pkg::OP_DIFF_IMM)
                work_r <= diff;
        end
        else if (!busy_r && reg_wr && reg_addr == ssa_pkg::ADDR_WORKING)
            work_r <= reg_wdata;
    end

    // status flags: of the operations only subtractions touch them; software writes while idle
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            {ov_r, z_r, ac_r, c_r} <= ssa_pkg::FLAGS_RESET;
        else if (state_r == ssa_pkg::SSA_EXEC && is_sub)
        begin
            ov_r <= (work_r[7] ^ sub_rhs[7]) & (work_r[7] ^ diff[7]);
            z_r  <= (diff == 8'h00);
            ac_r <= (work_r[3:0] >= sub_rhs[3:0]);
            c_r  <= ~diff_w[8];
        end
        else if (!busy_r && reg_wr && reg_addr == ssa_pkg::ADDR_STATUS)
        begin
            ov_r <= reg_wdata[ssa_pkg::STATUS_SIGNED_BIT];
            z_r  <= reg_wdata[ssa_pkg::STATUS_NULL_BIT];
            ac_r <= reg_wdata[ssa_pkg::STATUS_HALF_CARRY_BIT];
            c_r  <= reg_wdata[ssa_pkg::STATUS_BORROW_INV_BIT];
        end
    end

    // data memory: exec write-back, else software writes while idle
    always_ff @(posedge ref_clk)
    begin
        if (state_r == ssa_pkg::SSA_EXEC && code_r == ssa_pkg::OP_INC_SKIP_ZERO)
            mem_r[addr_r] <= inc_val;
        else if (state_r == ssa_pkg::SSA_EXEC && code_r == ssa_pkg::OP_DIFF_TO_MEM)
            mem_r[addr_r] <= diff;
        else if (!busy_r && reg_wr && reg_addr <= ssa_pkg::ADDR_MEM_LAST)
            mem_r[reg_addr[7:0]] <= reg_wdata;
    end

    // register read, data stands in the following cycle only
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_r <= 8'h00;
        else if (!reg_rd)
            rdata_r <= 8'h00;
        else if (reg_addr <= ssa_pkg::ADDR_MEM_LAST)
            rdata_r <= mem_r[reg_addr[7:0]];
        else if (reg_addr == ssa_pkg::ADDR_WORKING)
            rdata_r <= work_r;
        else if (reg_addr == ssa_pkg::ADDR_STATUS)
        begin
            rdata_r <= 8'h00;
            rdata_r[ssa_pkg::STATUS_SIGNED_BIT]     <= ov_r;
            rdata_r[ssa_pkg::STATUS_NULL_BIT]       <= z_r;
            rdata_r[ssa_pkg::STATUS_HALF_CARRY_BIT] <= ac_r;
            rdata_r[ssa_pkg::STATUS_BORROW_INV_BIT] <= c_r;
            rdata_r[ssa_pkg::STATUS_BUSY_BIT]       <= busy_r;
        end
        else
            rdata_r <= 8'h00; // unmapped reads as zero
    end

    assign busy                = busy_r;
    assign done                = done_r;
    assign skip_taken          = skip_r;
    assign dummy_cycle         = dummy_r;
    assign reg_rdata           = rdata_r;
    assign working_register    = work_r;
    assign signed_range_flag   = ov_r;
    assign null_result_flag    = z_r;
    assign half_carry_flag     = ac_r;
    assign borrow_inverse_flag = c_r;

endmodule : ssa_alu

// >>> ssa_alu_chk.sv
// ssa_alu_chk: timing and arithmetic checks on the ssa_alu ports
// assumes: bound to ssa_alu, one clock, reset async active low
`timescale 1ns/1ns
module ssa_alu_chk (
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic       op_valid,
    input wire logic [2:0] op_code,
    input wire logic [7:0] op_imm,
    input wire logic       busy,
    input wire logic       done,
    input wire logic       skip_taken,
    input wire logic       dummy_cycle,
    input wire logic [7:0] working_register,
    input wire logic       signed_range_flag,
    input wire logic       null_result_flag,
    input wire logic       half_carry_flag,
    input wire logic       borrow_inverse_flag
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    // accepted request, and the accepted immediate subtraction
    wire logic take     = op_valid && !busy;
    wire logic take_imm = take && (op_code == ssa_pkg::OP_DIFF_IMM);
    wire logic [3:0] flags = {signed_range_flag, null_result_flag, half_carry_flag,
                              borrow_inverse_flag};
    // instruction timing, dummy cycle after a taken skip
    a_issue_busy: assert property (take |=> busy && !done)
        else $error("busy not raised after issue");
    a_done_bound: assert property (take |-> ##[2:3] done)
        else $error("done not seen within three cycles");
    a_skip_dummy: assert property (skip_taken |-> dummy_cycle && busy)
        else $error("skip without dummy cycle");
    a_dummy_done: assert property (dummy_cycle |=> done && !busy && !dummy_cycle)
        else $error("dummy cycle not followed by done");
    // increments and bit test keep the flags
    a_flags_kept: assert property (take && op_code < ssa_pkg::OP_DIFF_TO_WORK
        |=> ##1 $stable(flags))
        else $error("flags changed by a non-subtract operation");
    // immediate subtraction result and flags
    a_imm_diff: assert property (take_imm |=> ##1
        working_register == 8'($past(working_register, 2) - $past(op_imm, 2)))
        else $error("immediate difference wrong");
    a_imm_borrow: assert property (take_imm |=> ##1
        borrow_inverse_flag == ($past(working_register, 2) >= $past(op_imm, 2)))
        else $error("borrow flag wrong");
    a_imm_null: assert property (take_imm |=> ##1
        null_result_flag == (working_register == 8'h00))
        else $error("zero flag wrong");
    c_skip: cover property (skip_taken);
    c_plain: cover property (take ##2 done);
    c_imm: cover property (take_imm);
endmodule : ssa_alu_chk

bind ssa_alu ssa_alu_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .op_valid(op_valid),
    .op_code(op_code), .op_imm(op_imm), .busy(busy), .done(done), .skip_taken(skip_taken),
    .dummy_cycle(dummy_cycle), .working_register(working_register),
    .signed_range_flag(signed_range_flag), .null_result_flag(null_result_flag),
    .half_carry_flag(half_carry_flag), .borrow_inverse_flag(borrow_inverse_flag));

// >>> ssa_alu_tb_top.sv
// ssa_alu_tb_top: random self-checking run of every ssa_alu operation
// assumes: ssa_pkg and the bound checker compiled beforehand
`timescale 1ns/1ns
module ssa_alu_tb_top;
    logic       ref_clk, rst_n, op_valid, reg_wr, reg_rd, rd_pend, skip_seen, sk;
    logic [2:0] op_code, op_bit, c, bt;
    logic [7:0] op_addr, op_imm, reg_wdata, reg_rdata, working_register, ad, im, m_m, w_m, r, b;
    logic [8:0] reg_addr;
    logic [3:0] f_m;
    logic       busy, done, skip_taken, dummy_cycle, sgn_f, nul_f, hc_f, bi_f;
    logic [7:0] rq[$];
    logic       sq[$];
    int         miscompares, check_count, seed;

    ssa_alu u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code),
        .op_addr(op_addr), .op_bit(op_bit), .op_imm(op_imm), .busy(busy), .done(done),
        .skip_taken(skip_taken), .dummy_cycle(dummy_cycle), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .working_register(working_register), .signed_range_flag(sgn_f),
        .null_result_flag(nul_f), .half_carry_flag(hc_f), .borrow_inverse_flag(bi_f));

    // clock
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [7:0] e, input logic [7:0] g, input string nm);
        check_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic stop_test;
        if (miscompares == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test

    // one register write, or one read whose expected data is noted
    task automatic bus(input logic [8:0] a, input logic [7:0] d, input logic w);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= w ? d : 8'h00;
        reg_wr    <= w;
        reg_rd    <= !w;
        if (!w) rq.push_back(d);
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask : bus

    // issue one instruction, hold the request into the busy cycle where it is ignored
    task automatic op;
        sq.push_back(sk);
        @(posedge ref_clk);
        op_valid <= 1'b1;
        op_code  <= c;
        op_addr  <= ad;
        op_bit   <= bt;
        op_imm   <= im;
        @(posedge ref_clk);
        op_imm <= ~im;
        @(posedge ref_clk);
        op_valid <= 1'b0;
        repeat (3)
        begin
            @(negedge ref_clk);
            if (done === 1'b1) break;
        end
        chk(8'h01, {7'h00, done === 1'b1}, "done");
        chk(w_m, working_register, "working_register");
        chk({4'h0, f_m}, {4'h0, sgn_f, nul_f, hc_f, bi_f}, "flags");
    endtask : op

    // note read strobes; compare results against the oldest note
    always @(posedge ref_clk) rd_pend <= reg_rd;
    always @(negedge ref_clk)
    begin
        if (skip_taken === 1'b1) skip_seen = 1'b1;
        if (rst_n && rd_pend) chk(rq.pop_front(), reg_rdata, "reg_rdata");
        if (rst_n && done === 1'b1)
        begin
            chk({7'h00, sq.pop_front()}, {7'h00, skip_seen}, "skip");
            skip_seen = 1'b0;
        end
    end

    // watchdog
    initial
    begin
        repeat (8000) @(posedge ref_clk);
        miscompares++;
        stop_test();
    end

    // main sequence
    initial
    begin
        {rst_n, op_valid, reg_wr, reg_rd, skip_seen, op_code, op_bit, op_addr} = '0;
        {op_imm, reg_wdata, reg_addr} = '0;
        seed = 32'he6dd;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        bus(ssa_pkg::ADDR_WORKING, ssa_pkg::WORKING_RESET, 1'b0);
        bus(ssa_pkg::ADDR_STATUS, {4'h0, ssa_pkg::FLAGS_RESET}, 1'b0);
        bus(9'h150, 8'h5a, 1'b1);
        bus(9'h150, 8'h00, 1'b0);
        for (int i = 0; i < 120; i++)
        begin
            {ad, m_m, w_m, im} = $random(seed);
            {bt, f_m} = 7'($random(seed));
            if (i % 4 == 1 || i % 12 == 6) m_m = 8'hff; // wrap also for increment_skip_zero
            if (i % 4 == 2 || i % 12 == 3) w_m = m_m; // zero difference also into working
            c = 3'(i % 6);
            bus({1'b0, ad}, m_m, 1'b1);
            bus(ssa_pkg::ADDR_WORKING, w_m, 1'b1);
            bus(ssa_pkg::ADDR_STATUS, {4'h0, f_m}, 1'b1);
            r = m_m + 8'h01;
            sk = (c == ssa_pkg::OP_BIT_SET_SKIP) ? m_m[bt] : (c < 3'h2 && r == 8'h00);
            if (c == ssa_pkg::OP_INC_SKIP_ZERO) m_m = r;
            if (c == ssa_pkg::OP_INC_TO_WORKING) w_m = r;
            b = (c == ssa_pkg::OP_DIFF_IMM) ? im : m_m;
            r = w_m - b;
            if (c >= ssa_pkg::OP_DIFF_TO_WORK)
            begin
                f_m = {(w_m[7] != b[7]) && (r[7] != w_m[7]), r == 8'h00, w_m[3:0] >= b[3:0], w_m >= b};
                if (c == ssa_pkg::OP_DIFF_TO_MEM) m_m = r;
                else w_m = r;
            end
            op();
            bus(ssa_pkg::ADDR_WORKING, w_m, 1'b0);
            bus({1'b0, ad}, m_m, 1'b0);
            bus(ssa_pkg::ADDR_STATUS, {4'h0, f_m}, 1'b0);
        end
        repeat (2) @(posedge ref_clk);
        stop_test();
    end
endmodule : ssa_alu_tb_top
